// *** rtl/jump_cond_regs.vh ***
// Purpose: shared constants for the jump condition and add-with-carry block
// Assumes: included by bare name from rtl design files
// Notes: register offsets are local choices, byte-less word index map
`ifndef JUMP_COND_REGS_VH
`define JUMP_COND_REGS_VH

// condition field encodings
`define CC_NEVER 4'h0
`define CC_ALWAYS 4'h8
`define CC_CARRY_SET 4'h7
`define CC_CARRY_CLR 4'hf
`define CC_ZERO_SET 4'h6
`define CC_ZERO_CLR 4'he
`define CC_SIGN_CLR 4'hd
`define CC_SIGN_SET 4'h5
`define CC_WRAP_SET 4'h4
`define CC_WRAP_CLR 4'hc
`define CC_SGN_AT_LEAST 4'h9
`define CC_SGN_BELOW 4'h1
`define CC_SGN_ABOVE 4'ha
`define CC_SGN_AT_MOST 4'h2
`define CC_UNS_ABOVE 4'hb
`define CC_UNS_AT_MOST 4'h3

// flag bit positions in the flag register
`define FLAG_CARRY 3
`define FLAG_ZERO 2
`define FLAG_SIGN 1
`define FLAG_WRAP 0
`define FLAGS_RST 4'h0

// register port offsets
`define REG_FLAGS 4'h0
`define REG_DST 4'h1
`define REG_SRC 4'h2
`define REG_JUMP 4'h3
`define REG_COND 4'h4

// command codes written to the command register
`define CMD_ADC 8'h01
`define CMD_JUMP 8'h02

`endif

// *** rtl/cond_eval.v ***
// Purpose: combinational test of a jump condition field against flags
// Assumes: flags are the current stable flag register contents
// Notes: aliases fall out naturally since they share one encoding
`timescale 1ns/1ps
`include "jump_cond_regs.vh"
module cond_eval (
    input wire [3:0] jump_condition_field,
    input wire [3:0] flags,
    output reg taken
);
    wire c = flags[`FLAG_CARRY];
    wire z = flags[`FLAG_ZERO];
    wire s = flags[`FLAG_SIGN];
    wire v = flags[`FLAG_WRAP];
    wire sxv = s ^ v;

    always @* begin
        case (jump_condition_field)
            `CC_NEVER: taken = 1'b0; // see [RULE1]
            `CC_ALWAYS: taken = 1'b1; // see [RULE1]
            `CC_CARRY_SET: taken = c; // see [RULE3] see [RULE5]
            `CC_CARRY_CLR: taken = ~c; // see [RULE3] see [RULE5]
            `CC_ZERO_SET: taken = z; // see [RULE3] see [RULE5]
            `CC_ZERO_CLR: taken = ~z; // see [RULE3] see [RULE5]
            `CC_SIGN_CLR: taken = ~s; // see [RULE4]
            `CC_SIGN_SET: taken = s; // see [RULE4]
            `CC_WRAP_SET: taken = v; // see [RULE4]
            `CC_WRAP_CLR: taken = ~v; // see [RULE4]
            `CC_SGN_AT_LEAST: taken = ~sxv; // see [RULE6]
            `CC_SGN_BELOW: taken = sxv; // see [RULE6]
            `CC_SGN_ABOVE: taken = ~(z | sxv); // see [RULE6]
            `CC_SGN_AT_MOST: taken = z | sxv; // see [RULE6]
            `CC_UNS_ABOVE: taken = ~c & ~z; // see [RULE7]
            `CC_UNS_AT_MOST: taken = c | z; // see [RULE7]
            default: taken = 1'b0;
        endcase
    end
endmodule

// *** rtl/adc_unit.v ***
// Purpose: add-with-carry datapath and its flag results
// Assumes: operands and carry in are stable in the same cycle
// Notes: purely combinational, the caller registers the results
`timescale 1ns/1ps
`include "jump_cond_regs.vh"
module adc_unit #(
    parameter WIDTH = 8
) (
    input wire [WIDTH-1:0] dst,
    input wire [WIDTH-1:0] src,
    input wire carry_in,
    output wire [WIDTH-1:0] sum,
    output wire [3:0] flags
);
    wire [WIDTH:0] full;

    // two's complement add with carry in  see [RULE8] see [RULE9]
    assign full = {1'b0, dst} + {1'b0, src} + {{WIDTH{1'b0}}, carry_in};
    assign sum = full[WIDTH-1:0];
    assign flags[`FLAG_CARRY] = full[WIDTH]; // see [RULE10]
    assign flags[`FLAG_ZERO] = (sum == {WIDTH{1'b0}}); // see [RULE11]
    assign flags[`FLAG_SIGN] = sum[WIDTH-1]; // see [RULE11]
    // same-sign operands giving opposite-sign result  see [RULE12]
    assign flags[`FLAG_WRAP] = (dst[WIDTH-1] == src[WIDTH-1]) &&
                               (sum[WIDTH-1] != dst[WIDTH-1]);
endmodule

// *** rtl/jump_condition_and_add_carry.v ***
// What this block does
// [RULE1] 4-bit field; 0000 never, 1000 always
// [RULE2] jump only when condition true, else next
// [RULE3] carry and zero set/clear tests
// [RULE4] sign and overflow set/clear tests
// [RULE5] alias encodings decode identically
// [RULE6] signed tests use sign xor overflow
// [RULE7] unsigned above/at-most use carry and zero
// [RULE8] destination gets dst plus src plus carry
// [RULE9] two's complement, carry chains multi-byte
// [RULE10] carry flag from msb carry out
// [RULE11] zero and sign flags from result
// [RULE12] overflow on same-sign operand sign flip
// [RULE13] all four flags update with destination
//
// Purpose: condition evaluation for jumps and add-with-carry execution
// Assumes: strobes one cycle, never together; read data next cycle
// Notes: pc is held here so a jump's outcome is visible to software
`timescale 1ns/1ps
`include "jump_cond_regs.vh"
module jump_condition_and_add_carry #(
    parameter WIDTH = 8,
    parameter PC_WIDTH = 13
) (
    input wire core_clk,
    input wire rst_b,
    input wire [3:0] addr,
    input wire [15:0] wr_data,
    input wire wr_stb,
    input wire rd_stb,
    output reg [15:0] rd_data,
    output reg [3:0] flags_out,
    output reg [WIDTH-1:0] dst_out,
    output reg [PC_WIDTH-1:0] pc_out,
    output reg jump_taken,
    output reg step_done
);
    localparam ST_IDLE = 1'b0;
    localparam ST_EXEC = 1'b1;

    reg [3:0] flags_r;
    reg [WIDTH-1:0] dst_r;
    reg [WIDTH-1:0] src_r;
    reg [PC_WIDTH-1:0] pc_r;
    reg [PC_WIDTH-1:0] target_r;
    reg [3:0] cond_r;
    reg [7:0] cmd_r;
    reg state_r;
    reg taken_r;
    reg [15:0] rd_data_nxt;

    wire [WIDTH-1:0] sum;
    wire [3:0] adc_flags;
    wire cond_true;

    cond_eval u_cond (
        .jump_condition_field(cond_r),
        .flags(flags_r),
        .taken(cond_true)
    );

    adc_unit #(.WIDTH(WIDTH)) u_adc (
        .dst(dst_r),
        .src(src_r),
        .carry_in(flags_r[`FLAG_CARRY]),
        .sum(sum),
        .flags(adc_flags)
    );

    function [15:0] zext_pc;
        input [PC_WIDTH-1:0] v;
        begin
            zext_pc = {{(16-PC_WIDTH){1'b0}}, v};
        end
    endfunction

    // read mux: unmapped offsets answer zero
    always @* begin
        rd_data_nxt = 16'h0000;
        case (addr)
            `REG_FLAGS: rd_data_nxt = {12'h000, flags_r};
            `REG_DST: rd_data_nxt = {{(16-WIDTH){1'b0}}, dst_r};
            `REG_SRC: rd_data_nxt = {{(16-WIDTH){1'b0}}, src_r};
            `REG_JUMP: rd_data_nxt = zext_pc(pc_r);
            `REG_COND: rd_data_nxt = {11'h000, taken_r, cond_r};
            default: rd_data_nxt = 16'h0000;
        endcase
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_r <= `FLAGS_RST;
            dst_r <= {WIDTH{1'b0}};
            src_r <= {WIDTH{1'b0}};
            pc_r <= {PC_WIDTH{1'b0}};
            target_r <= {PC_WIDTH{1'b0}};
            cond_r <= `CC_NEVER;
            cmd_r <= 8'h00;
            state_r <= ST_IDLE;
            taken_r <= 1'b0;
            rd_data <= 16'h0000;
            flags_out <= 4'h0;
            dst_out <= {WIDTH{1'b0}};
            pc_out <= {PC_WIDTH{1'b0}};
            jump_taken <= 1'b0;
            step_done <= 1'b0;
        end else begin
            rd_data <= rd_stb ? rd_data_nxt : 16'h0000;
            step_done <= 1'b0;
            if (wr_stb && state_r == ST_IDLE) begin
                case (addr)
                    `REG_FLAGS: flags_r <= wr_data[3:0];
                    `REG_DST: dst_r <= wr_data[WIDTH-1:0];
                    `REG_SRC: src_r <= wr_data[WIDTH-1:0];
                    `REG_JUMP: target_r <= wr_data[PC_WIDTH-1:0];
                    `REG_COND: begin
                        // upper byte is the command, low nibble the field
                        cond_r <= wr_data[3:0];
                        cmd_r <= wr_data[15:8];
                        state_r <= ST_EXEC;
                    end
                    default: ;
                endcase
            end else if (state_r == ST_EXEC) begin
                state_r <= ST_IDLE;
                step_done <= 1'b1;
                case (cmd_r)
                    `CMD_ADC: begin
                        // sum and all four flags land in one edge
                        dst_r <= sum; // see [RULE8] see [RULE13]
                        flags_r <= adc_flags; // see [RULE13]
                    end
                    `CMD_JUMP: begin
                        taken_r <= cond_true; // see [RULE2]
                        if (cond_true)
                            pc_r <= target_r; // see [RULE2]
                        else
                            pc_r <= pc_r + {{(PC_WIDTH-1){1'b0}}, 1'b1};
                    end
                    default: ;
                endcase
            end
            flags_out <= flags_r;
            dst_out <= dst_r;
            pc_out <= pc_r;
            jump_taken <= taken_r;
        end
    end
endmodule

// *** tb/jcac_assertions.sv ***
// Purpose: port checks for jump outcome and add-with-carry flags
// Assumes: one command in flight, idle gap after each command
// Notes: flag bits are carry, zero, sign, wrap from msb down
`timescale 1ns/1ps
module jcac_assertions #(parameter WIDTH = 8, parameter PC_WIDTH = 13) (
    input logic core_clk,
    input logic rst_b,
    input logic [3:0] addr,
    input logic [15:0] wr_data,
    input logic wr_stb,
    input logic rd_stb,
    input logic [15:0] rd_data,
    input logic [3:0] flags_out,
    input logic [WIDTH-1:0] dst_out,
    input logic [PC_WIDTH-1:0] pc_out,
    input logic jump_taken,
    input logic step_done
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire cmd = wr_stb && addr == 4'h4;
    wire adc = cmd && wr_data[15:8] == 8'h01;
    wire jmp = cmd && wr_data[15:8] == 8'h02;
    property p_adc_done;
        adc |-> ##2 step_done;
    endproperty
    a_adc_done: assert property (p_adc_done)
        else $error("no step_done");
    property p_zs;
        adc |-> ##3 flags_out[2] == (dst_out == 0) &&
            flags_out[1] == dst_out[WIDTH-1];
    endproperty
    a_zs: assert property (p_zs)
        else $error("zero or sign wrong");
    property p_never;
        jmp && wr_data[3:0] == 4'h0 |->
            ##3 !jump_taken && pc_out == $past(pc_out, 3) + 1'b1;
    endproperty
    a_never: assert property (p_never)
        else $error("never code jumped");
    property p_always;
        jmp && wr_data[3:0] == 4'h8 |-> ##3 jump_taken;
    endproperty
    a_always: assert property (p_always)
        else $error("always missed");
    property p_carry;
        jmp && wr_data[3:0] == 4'h7 |-> ##3 jump_taken == flags_out[3];
    endproperty
    a_carry: assert property (p_carry)
        else $error("carry test wrong");
    property p_sign;
        jmp && wr_data[3:0] == 4'h5 |-> ##3 jump_taken == flags_out[1];
    endproperty
    a_sign: assert property (p_sign)
        else $error("sign test wrong");
    property p_uns;
        jmp && wr_data[3:0] == 4'hb |->
            ##3 jump_taken == !(flags_out[3] | flags_out[2]);
    endproperty
    a_uns: assert property (p_uns)
        else $error("above test wrong");
    property p_frd;
        rd_stb && addr == 4'h0 |=> rd_data[3:0] == flags_out;
    endproperty
    a_frd: assert property (p_frd)
        else $error("flag read wrong");
endmodule
bind jump_condition_and_add_carry jcac_assertions #(.WIDTH(WIDTH),
    .PC_WIDTH(PC_WIDTH)) jcac_assertions_i (.core_clk(core_clk),
    .rst_b(rst_b), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .flags_out(flags_out),
    .dst_out(dst_out), .pc_out(pc_out), .jump_taken(jump_taken),
    .step_done(step_done));

// *** tb/testbench.sv ***
// Purpose: self-checking bench for jump tests and add-with-carry
// Assumes: command results show two edges after the command write
// Notes: flags are rewritten before every third add, else left alone so the carry chains
`timescale 1ns/1ps
`include "jump_cond_regs.vh"
module testbench;
    reg core_clk = 1'b0;
    reg rst_b = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [15:0] wr_data = 16'h0;
    reg wr_stb = 1'b0;
    reg rd_stb = 1'b0;
    wire [15:0] rd_data;
    wire [3:0] flags_out;
    wire [7:0] dst_out;
    wire [12:0] pc_out;
    wire jump_taken;
    wire step_done;
    integer fails = 0;
    integer samples_checked = 0;
    integer cycles = 0;
    integer i;
    reg [3:0] fl;
    reg [3:0] cc;
    reg [12:0] pc;
    reg [12:0] tgt;
    reg [7:0] d;
    reg [7:0] s;
    reg [8:0] sum;
    reg [15:0] rv;
    reg t;
    jump_condition_and_add_carry jump_condition_and_add_carry_i (
        .core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wr_data(wr_data),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .flags_out(flags_out), .dst_out(dst_out), .pc_out(pc_out),
        .jump_taken(jump_taken), .step_done(step_done));
    always #25 core_clk = ~core_clk;
    function cond(input [3:0] c, input [3:0] f);
        case (c)
            4'h0: cond = 1'b0;
            4'h8: cond = 1'b1;
            4'h7: cond = f[3];
            4'hf: cond = !f[3];
            4'h6: cond = f[2];
            4'he: cond = !f[2];
            4'hd: cond = !f[1];
            4'h5: cond = f[1];
            4'h4: cond = f[0];
            4'hc: cond = !f[0];
            4'h9: cond = !(f[1] ^ f[0]);
            4'h1: cond = f[1] ^ f[0];
            4'ha: cond = !(f[2] | (f[1] ^ f[0]));
            4'h2: cond = f[2] | (f[1] ^ f[0]);
            4'hb: cond = !f[3] && !f[2];
            default: cond = f[3] | f[2];
        endcase
    endfunction
    task chk(input string nm, input [15:0] e, input [15:0] g);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("Error %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [3:0] a, input [15:0] v);
        @(posedge core_clk);
        addr <= a;
        wr_data <= v;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask
    task rd(input [3:0] a, output [15:0] v);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1 v = rd_data;
    endtask
    task cmd(input [15:0] v);
        wr(`REG_COND, v);
        @(posedge core_clk);
        #1 chk("step_done", 16'h1, 16'(step_done));
        @(posedge core_clk);
        #1;
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // a hung handshake would otherwise stall the run forever
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            wrap_up;
        end
    end
    initial begin
        void'($urandom(32'h29bd));
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        pc = 13'h0;
        for (i = 0; i < 256; i = i + 1) begin
            fl = i[3:0];
            cc = i[7:4];
            tgt = 13'($urandom);
            t = cond(cc, fl);
            wr(`REG_FLAGS, {12'h0, fl});
            wr(`REG_JUMP, {3'h0, tgt});
            cmd({`CMD_JUMP, 4'h0, cc});
            pc = t ? tgt : pc + 13'h1;
            chk("taken", 16'(t), 16'(jump_taken));
            chk("pc", 16'(pc), 16'(pc_out));
            rd(`REG_COND, rv);
            chk("cond_rd", {11'h0, t, cc}, rv);
        end
        for (i = 0; i < 200; i = i + 1) begin
            d = 8'($urandom);
            s = 8'($urandom);
            if (i % 3 == 0) begin
                fl = 4'($urandom);
                wr(`REG_FLAGS, {12'h0, fl});
            end
            wr(`REG_DST, {8'h0, d});
            wr(`REG_SRC, {8'h0, s});
            cmd({`CMD_ADC, 8'h0});
            sum = d + s + fl[3];
            fl[3] = sum[8];
            fl[2] = sum[7:0] == 8'h00;
            fl[1] = sum[7];
            fl[0] = d[7] == s[7] && sum[7] != d[7];
            chk("dst", 16'(sum[7:0]), 16'(dst_out));
            chk("flags", 16'(fl), 16'(flags_out));
            rd(`REG_FLAGS, rv);
            chk("flags_rd", 16'(fl), rv);
        end
        wrap_up;
    end
endmodule
